// ===== design/adc_clock_power_output_ctrl.sv
`timescale 1ns/1ps
// clock, power and output control around the pipelined converter
module adc_clock_power_output_ctrl #(
    parameter int DEFAULT_RATIO = 1
) (
    // clock and reset
    input  wire logic                                   ref_clk,
    input  wire logic                                   rstn,
    // converter core sample, same clock domain
    input  wire logic [adc_ctrl_pkg::SAMPLE_W-1:0]      core_sample,
    // serial port pins
    input  wire logic                                   spi_sclk,
    input  wire logic                                   spi_csb,
    input  wire logic                                   spi_sdio_in,
    output logic                                        spi_sdio_out,
    output logic                                        spi_sdio_oe,
    // lvds output pins
    output adc_ctrl_pkg::lvds_out_type                  lvds_out,
    // analog controls
    output logic                                        internal_sample_clk,
    output logic                                        reference_power_on,
    output logic                                        bias_power_on,
    output logic [7:0]                                  vref_trim,
    output logic                                        requantizer_enable
);

    localparam int PIPE_D = adc_ctrl_pkg::LATENCY_REQUANT;

    // output encoding from raw offset binary
    function automatic logic [adc_ctrl_pkg::SAMPLE_W-1:0] encode(
        input logic [adc_ctrl_pkg::SAMPLE_W-1:0] raw,
        input logic [1:0]                        fmt
    );
        logic [adc_ctrl_pkg::SAMPLE_W-1:0] res;
        res = raw;
        if (fmt == adc_ctrl_pkg::FMT_TWOS) begin
            res = {~raw[adc_ctrl_pkg::SAMPLE_W-1], raw[adc_ctrl_pkg::SAMPLE_W-2:0]};
        end else if (fmt == adc_ctrl_pkg::FMT_GRAY) begin
            res = raw ^ (raw >> 1);
        end
        return res; // see RULE_11
    endfunction

    // stabilizer usable only at or above its minimum rate
    function automatic logic dcs_usable(input logic [2:0] ratio_m1);
        int rate;
        rate = adc_ctrl_pkg::REF_CLK_HZ / (int'(ratio_m1) + 1);
        return rate >= adc_ctrl_pkg::DCS_MIN_HZ; // see RULE_04
    endfunction

    // ---------------- serial port synchronisers ----------------
    logic sclk_meta;  // first stage, read by sclk_sync only
    logic sclk_sync;  // synchronised serial clock
    logic sclk_last;  // previous synchronised value
    logic csb_meta;   // first stage
    logic csb_sync;   // synchronised chip select
    logic sdio_meta;  // first stage
    logic sdio_sync;  // synchronised data in

    // two flops on every pin before use
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sclk_meta <= 1'b0;
            sclk_sync <= 1'b0;
            sclk_last <= 1'b0;
            csb_meta  <= 1'b1;
            csb_sync  <= 1'b1;
            sdio_meta <= 1'b0;
            sdio_sync <= 1'b0;
        end else begin
            sclk_meta <= spi_sclk;
            sclk_sync <= sclk_meta;
            sclk_last <= sclk_sync;
            csb_meta  <= spi_csb;
            csb_sync  <= csb_meta;
            sdio_meta <= spi_sdio_in;
            sdio_sync <= sdio_meta;
        end
    end

    wire sclk_rise = sclk_sync && !sclk_last; // sampling edge
    wire sclk_fall = !sclk_sync && sclk_last; // launch edge for reads

    // ---------------- serial frame engine ----------------
    adc_ctrl_pkg::spi_state_type state;       // frame phase
    adc_ctrl_pkg::spi_state_type next_state;  // next frame phase
    logic [4:0]                  bit_cnt;     // bit inside current phase
    logic [15:0]                 shift_in;    // incoming bits
    logic [12:0]                 addr;        // current register address
    logic [7:0]                  rd_shift;    // outgoing read byte
    logic                        wr_strobe;   // one-cycle register write
    logic [7:0]                  wr_data;     // byte being written
    logic [12:0]                 wr_addr;     // address the written byte belongs to
    logic [7:0]                  rd_data;     // read mux result
    logic [7:0]                  rd_next;     // read mux at next address

    wire instr_done = sclk_rise && (bit_cnt == 5'(adc_ctrl_pkg::INSTR_BITS - 1));
    wire byte_done  = sclk_rise && (bit_cnt == 5'(adc_ctrl_pkg::DATA_BITS - 1));
    wire [15:0] instr_word = {shift_in[14:0], sdio_sync};

    // phase sequencing; chip select high ends any frame
    always_comb begin
        next_state = state;
        if (csb_sync) begin
            next_state = adc_ctrl_pkg::SPI_IDLE;
        end else begin
            case (state)
                adc_ctrl_pkg::SPI_IDLE: begin
                    next_state = adc_ctrl_pkg::SPI_INSTR;
                end
                adc_ctrl_pkg::SPI_INSTR: begin
                    if (instr_done) begin
                        next_state = instr_word[adc_ctrl_pkg::READ_BIT]
                                   ? adc_ctrl_pkg::SPI_READ : adc_ctrl_pkg::SPI_WRITE;
                    end
                end
                default: begin
                    next_state = state; // streaming stays in data phase
                end
            endcase
        end
    end

    // state, bit counter and address
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state   <= adc_ctrl_pkg::SPI_IDLE;
            bit_cnt <= 5'h00;
            addr    <= 13'h0000;
        end else begin
            state <= next_state;
            if (state == adc_ctrl_pkg::SPI_IDLE) begin
                bit_cnt <= 5'h00;
            end else if (instr_done && state == adc_ctrl_pkg::SPI_INSTR) begin
                bit_cnt <= 5'h00;
                addr    <= instr_word[12:0];
            end else if (byte_done && state != adc_ctrl_pkg::SPI_INSTR) begin
                bit_cnt <= 5'h00;
                addr    <= addr + 13'h0001; // streaming walks upward
            end else if (sclk_rise) begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // input shifter and write strobe
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            shift_in  <= 16'h0000;
            wr_strobe <= 1'b0;
            wr_data   <= 8'h00;
            wr_addr   <= 13'h0000;
        end else begin
            wr_strobe <= byte_done && state == adc_ctrl_pkg::SPI_WRITE && !csb_sync;
            wr_data   <= {shift_in[6:0], sdio_sync};
            wr_addr   <= addr; // addr steps on at the same edge, so keep the old one
            if (sclk_rise) begin
                shift_in <= {shift_in[14:0], sdio_sync};
            end
        end
    end

    // read byte shifts out msb first on falling edges
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rd_shift     <= 8'h00;
            spi_sdio_out <= 1'b0;
            spi_sdio_oe  <= 1'b0;
        end else begin
            spi_sdio_oe <= (state == adc_ctrl_pkg::SPI_READ) && !csb_sync;
            if (state == adc_ctrl_pkg::SPI_INSTR && instr_done) begin
                rd_shift <= rd_data;
            end else if (state == adc_ctrl_pkg::SPI_READ && byte_done) begin
                rd_shift <= rd_next;
            end else if (state == adc_ctrl_pkg::SPI_READ && sclk_fall) begin
                spi_sdio_out <= rd_shift[7];
                rd_shift     <= {rd_shift[6:0], 1'b0};
            end
        end
    end

    // ---------------- register file ----------------
    logic [7:0] power_mode_control;   // power mode field
    logic [7:0] output_mode_control;  // format, three-state, swing
    logic [7:0] dcs_control;          // stabilizer enable
    logic [7:0] clock_divide_control; // divide ratio minus one
    logic [7:0] vref_control;         // reference setting
    logic [7:0] requant_control;      // requantizer enable
    logic [7:0] clock_status;         // read-only clock and power state

    wire wr_power  = wr_strobe && (wr_addr == adc_ctrl_pkg::ADDR_POWER_MODE);
    wire wr_dcs    = wr_strobe && (wr_addr == adc_ctrl_pkg::ADDR_DCS_CTRL);
    wire wr_divide = wr_strobe && (wr_addr == adc_ctrl_pkg::ADDR_CLK_DIVIDE);
    wire wr_output = wr_strobe && (wr_addr == adc_ctrl_pkg::ADDR_OUTPUT_MODE);
    wire wr_vref   = wr_strobe && (wr_addr == adc_ctrl_pkg::ADDR_VREF);
    wire wr_req    = wr_strobe && (wr_addr == adc_ctrl_pkg::ADDR_REQUANT);

    // stabilizer on at power-up whenever the ratio is not one
    localparam logic [7:0] DCS_RST = (DEFAULT_RATIO != 1) ? 8'h01 : 8'h00; // see RULE_02
    localparam logic [7:0] DIV_RST = 8'(DEFAULT_RATIO - 1);

    // register writes from the serial port
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            power_mode_control   <= adc_ctrl_pkg::POWER_MODE_RST;
            output_mode_control  <= adc_ctrl_pkg::OUTPUT_MODE_RST; // see RULE_21
            dcs_control          <= DCS_RST;
            clock_divide_control <= DIV_RST;
            vref_control         <= adc_ctrl_pkg::VREF_RST;
            requant_control      <= adc_ctrl_pkg::REQUANT_RST;
        end else begin
            if (wr_power)  power_mode_control   <= wr_data;
            if (wr_output) output_mode_control  <= wr_data;
            if (wr_dcs)    dcs_control          <= wr_data;
            if (wr_divide) clock_divide_control <= {5'h00, wr_data[2:0]};
            if (wr_vref)   vref_control         <= wr_data;
            if (wr_req)    requant_control      <= wr_data;
        end
    end

    // read selection, unmapped addresses read zero
    function automatic logic [7:0] reg_read(input logic [12:0] a);
        logic [7:0] v;
        v = 8'h00;
        if (a == adc_ctrl_pkg::ADDR_POWER_MODE) begin
            v = power_mode_control;
        end else if (a == adc_ctrl_pkg::ADDR_DCS_CTRL) begin
            v = dcs_control;
        end else if (a == adc_ctrl_pkg::ADDR_CLK_STATUS) begin
            v = clock_status;
        end else if (a == adc_ctrl_pkg::ADDR_CLK_DIVIDE) begin
            v = clock_divide_control;
        end else if (a == adc_ctrl_pkg::ADDR_OUTPUT_MODE) begin
            v = output_mode_control;
        end else if (a == adc_ctrl_pkg::ADDR_VREF) begin
            v = vref_control;
        end else if (a == adc_ctrl_pkg::ADDR_REQUANT) begin
            v = requant_control;
        end
        return v;
    endfunction

    assign rd_data = reg_read(instr_word[12:0]);
    assign rd_next = reg_read(addr + 13'h0001);

    // ---------------- power modes ----------------
    wire [1:0] pm_field = power_mode_control[adc_ctrl_pkg::PM_LSB +: 2];
    wire pm_down    = (pm_field == adc_ctrl_pkg::PM_POWER_DOWN);  // see RULE_07
    wire pm_standby = (pm_field == adc_ctrl_pkg::PM_STANDBY);     // see RULE_10
    wire pm_normal  = !pm_down && !pm_standby;                    // see RULE_22

    logic [7:0] wake_cnt; // cycles still needed to come back up
    wire        awake = pm_normal && (wake_cnt == 8'h00);

    // discharge grows while down; standby only needs a short wake
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            wake_cnt <= 8'h00;
        end else if (pm_down) begin
            if (wake_cnt != 8'(adc_ctrl_pkg::WAKE_MAX_CYC)) begin
                wake_cnt <= wake_cnt + 8'h01; // see RULE_09
            end
        end else if (pm_standby) begin
            wake_cnt <= 8'(adc_ctrl_pkg::STANDBY_WAKE_CYC);
        end else if (wake_cnt != 8'h00) begin
            wake_cnt <= wake_cnt - 8'h01;
        end
    end

    // analog enables
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            reference_power_on <= 1'b0;
            bias_power_on      <= 1'b0;
            vref_trim          <= adc_ctrl_pkg::VREF_RST;
            requantizer_enable <= 1'b0;
        end else begin
            reference_power_on <= !pm_down;            // see RULE_10
            bias_power_on      <= pm_normal;           // see RULE_09
            vref_trim          <= vref_control;        // see RULE_18
            requantizer_enable <= requant_control[adc_ctrl_pkg::REQ_EN_BIT];
        end
    end

    // ---------------- clock divider and stabilizer ----------------
    wire [2:0] ratio_m1 = clock_divide_control[2:0];
    logic [2:0] ratio_seen;  // ratio seen on the previous cycle
    logic [7:0] relock_cnt;  // cycles left before lock
    logic       dcs_locked;  // loop locked to current rate

    wire dcs_enable = dcs_control[adc_ctrl_pkg::DCS_EN_BIT];
    wire rate_change = (ratio_m1 != ratio_seen) || !awake;
    wire dcs_active  = dcs_enable && dcs_locked && dcs_usable(ratio_m1);

    // any rate change or clock stop restarts the lock wait
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ratio_seen <= 3'h0;
            relock_cnt <= 8'(adc_ctrl_pkg::RELOCK_MAX_CYC);
            dcs_locked <= 1'b0;
        end else begin
            ratio_seen <= ratio_m1;
            if (rate_change) begin
                relock_cnt <= 8'(adc_ctrl_pkg::RELOCK_MAX_CYC); // see RULE_05
                dcs_locked <= 1'b0;
            end else if (relock_cnt != 8'h00) begin
                relock_cnt <= relock_cnt - 8'h01;
            end else begin
                dcs_locked <= dcs_usable(ratio_m1); // see RULE_04
            end
        end
    end

    logic sample_tick;  // internal sample clock rising edge
    logic sample_level; // internal sample clock level

    sample_clock_divider #(
        .MAX_RATIO (adc_ctrl_pkg::MAX_RATIO)
    ) u_divider (
        .ref_clk    (ref_clk),
        .rstn       (rstn),
        .run        (awake),
        .ratio_m1   (ratio_m1),
        .dcs_active (dcs_active),
        .tick       (sample_tick),
        .clk_level  (sample_level)
    );

    // status register contents
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            clock_status        <= 8'h00;
            internal_sample_clk <= 1'b0;
        end else begin
            clock_status <= {5'h00, awake, dcs_active, dcs_locked};
            internal_sample_clk <= sample_level; // see RULE_06
        end
    end

    // ---------------- sample pipeline ----------------
    logic [adc_ctrl_pkg::SAMPLE_W-1:0] pipe [PIPE_D]; // samples in flight
    wire  requant_on = requant_control[adc_ctrl_pkg::REQ_EN_BIT];
    wire  [adc_ctrl_pkg::SAMPLE_W-1:0] tap = requant_on
                                           ? pipe[adc_ctrl_pkg::LATENCY_REQUANT - 1]
                                           : pipe[adc_ctrl_pkg::LATENCY_PLAIN - 1]; // see RULE_13

    // capture on each internal rising edge and shift along
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < PIPE_D; i++) pipe[i] <= '0;
        end else if (sample_tick) begin
            pipe[0] <= core_sample; // see RULE_20
            for (int i = 1; i < PIPE_D; i++) pipe[i] <= pipe[i-1];
        end
    end

    // ---------------- lvds output stage ----------------
    wire three_state = output_mode_control[adc_ctrl_pkg::OM_THREE_STATE];

    // data launched on the rising edge, enables follow power state
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            lvds_out <= '0;
        end else begin
            if (sample_tick) begin
                lvds_out.data <= encode(tap, output_mode_control[adc_ctrl_pkg::OM_FORMAT_LSB +: 2]); // see RULE_14
            end
            lvds_out.data_capture_clock_out     <= sample_level;               // see RULE_15
            lvds_out.dco_oe  <= awake;                       // see RULE_08
            lvds_out.data_oe <= awake && !three_state;       // see RULE_12
            lvds_out.reduced_swing <= output_mode_control[adc_ctrl_pkg::OM_REDUCED_SWING]; // see RULE_17
        end
    end

endmodule // adc_clock_power_output_ctrl

// ===== design/sample_clock_divider.sv
`timescale 1ns/1ps
// integer divider with duty shaping of the internal sample clock
module sample_clock_divider #(
    parameter int MAX_RATIO = 8
) (
    // clock and reset
    input  wire logic       ref_clk,
    input  wire logic       rstn,
    // control
    input  wire logic       run,
    input  wire logic [2:0] ratio_m1,
    input  wire logic       dcs_active,
    // results
    output logic            tick,
    output logic            clk_level
);

    logic [2:0] count;      // position inside one divided period
    wire  [2:0] half_point; // first count of the low phase
    wire        count_last; // last count of the period

    // regenerated falling edge sits at half the period, rounded up
    assign half_point = 3'((4'(ratio_m1) + 4'h2) >> 1); // see RULE_03
    assign count_last = (count >= ratio_m1);

    // period counter, held at zero while the clock is stopped
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            count <= 3'h0;
        end else if (!run || count_last) begin
            count <= 3'h0; // see RULE_01
        end else begin
            count <= count + 3'h1;
        end
    end

    // rising edge pulse and clock level
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            tick      <= 1'b0;
            clk_level <= 1'b0;
        end else begin
            tick <= run && (count == 3'h0);
            if (!run) begin
                clk_level <= 1'b0;
            end else if (dcs_active) begin
                clk_level <= (count < half_point); // see RULE_03
            end else begin
                // bypass: high for one input period only
                clk_level <= (count == 3'h0); // see RULE_06
            end
        end
    end

endmodule // sample_clock_divider

// ===== shared/adc_ctrl_pkg.sv
// Operation
// RULE_01: input clock divided by integer one to eight
// RULE_02: stabilizer defaults on when divide ratio not one
// RULE_03: locked stabilizer regenerates falling edge, 50% duty
// RULE_04: stabilizer unusable below nominal 40 MHz
// RULE_05: relock takes 1.5 to 5 microseconds
// RULE_06: unlocked stabilizer bypassed, input duty passes through; the bypass here is high for one input period per divided period
// RULE_07: power mode 01 at 0x08 is full power-down
// RULE_08: power-down holds every output driver high-impedance
// RULE_09: power-down stops reference, bias, clock; slower wake
// RULE_10: power mode 10 is standby, reference kept on
// RULE_11: output encoding offset binary, twos complement or gray
// RULE_12: bit 4 of 0x14 three-states data outputs
// RULE_13: latency 10 cycles, 13 with requantizer on
// RULE_14: each output word launched on sample rising edge
// RULE_15: data capture clock driven beside the samples
// RULE_16: source keeps conversion rate at least 40 MSPS
// RULE_17: drivers select standard or reduced swing signalling
// RULE_18: reference setting adjusts full-scale span linearly
// RULE_19: software keeps stabilizer on unless clock changes
// RULE_20: input sampled on internal clock rising edge
// RULE_21: encoding resets to twos complement
// RULE_22: power mode 00 is normal operation
package adc_ctrl_pkg;

    // clock and timing
    localparam int CLK_PERIOD_NS     = 25;
    localparam int REF_CLK_HZ        = 40000000;
    localparam int DCS_MIN_HZ        = 40000000;
    localparam int DCS_RELOCK_MIN_NS = 1500;
    localparam int DCS_RELOCK_MAX_NS = 5000;
    localparam int RELOCK_MIN_CYC    = (DCS_RELOCK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RELOCK_MAX_CYC    = DCS_RELOCK_MAX_NS / CLK_PERIOD_NS;
    localparam int WAKE_MAX_CYC      = 255;
    localparam int STANDBY_WAKE_CYC  = 4;

    // data path
    localparam int SAMPLE_W          = 11;
    localparam int LATENCY_PLAIN     = 10;
    localparam int LATENCY_REQUANT   = 13;
    localparam int MAX_RATIO         = 8;

    // serial port framing
    localparam int ADDR_W            = 13;
    localparam int INSTR_BITS        = 16;
    localparam int DATA_BITS         = 8;
    localparam int READ_BIT          = 15;

    // register offsets
    localparam logic [12:0] ADDR_POWER_MODE  = 13'h008;
    localparam logic [12:0] ADDR_DCS_CTRL    = 13'h009;
    localparam logic [12:0] ADDR_CLK_STATUS  = 13'h00a;
    localparam logic [12:0] ADDR_CLK_DIVIDE  = 13'h00b;
    localparam logic [12:0] ADDR_OUTPUT_MODE = 13'h014;
    localparam logic [12:0] ADDR_VREF        = 13'h018;
    localparam logic [12:0] ADDR_REQUANT     = 13'h03c;

    // field positions
    localparam int PM_LSB            = 0;
    localparam int OM_FORMAT_LSB     = 0;
    localparam int OM_THREE_STATE    = 4;
    localparam int OM_REDUCED_SWING  = 6;
    localparam int DCS_EN_BIT        = 0;
    localparam int REQ_EN_BIT        = 0;
    localparam int ST_LOCKED_BIT     = 0;
    localparam int ST_ACTIVE_BIT     = 1;
    localparam int ST_AWAKE_BIT      = 2;

    // reset values
    localparam logic [7:0] POWER_MODE_RST  = 8'h00;
    localparam logic [7:0] OUTPUT_MODE_RST = 8'h01;
    localparam logic [7:0] VREF_RST        = 8'h00;
    localparam logic [7:0] REQUANT_RST     = 8'h00;

    typedef enum logic [1:0] {
        PM_NORMAL     = 2'b00,
        PM_POWER_DOWN = 2'b01,
        PM_STANDBY    = 2'b10,
        PM_SPARE      = 2'b11
    } power_mode_type;

    typedef enum logic [1:0] {
        FMT_OFFSET_BINARY = 2'b00,
        FMT_TWOS          = 2'b01,
        FMT_GRAY          = 2'b10,
        FMT_SPARE         = 2'b11
    } data_format_type;

    typedef enum logic [1:0] {
        SPI_IDLE  = 2'b00,
        SPI_INSTR = 2'b01,
        SPI_WRITE = 2'b10,
        SPI_READ  = 2'b11
    } spi_state_type;

    // everything that leaves on the lvds pins
    typedef struct packed {
        logic [SAMPLE_W-1:0] data;
        logic                data_oe;
        logic                data_capture_clock_out;
        logic                dco_oe;
        logic                reduced_swing;
    } lvds_out_type;

endpackage

// ===== sim/adc_ctrl_monitor.sv
`timescale 1ns/1ps
// pin-level checker for the control block
module adc_ctrl_monitor (
    // clock and reset
    input wire logic                       ref_clk,
    input wire logic                       rstn,
    // watched pins
    input wire logic                       spi_csb,
    input wire logic                       spi_sdio_oe,
    input wire adc_ctrl_pkg::lvds_out_type lvds_out,
    input wire logic                       internal_sample_clk,
    input wire logic                       reference_power_on,
    input wire logic                       bias_power_on,
    input wire logic [7:0]                 vref_trim
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rstn);
    // power-down held for two samples
    sequence down_s; !reference_power_on [*2]; endsequence
    // standby held for two samples
    sequence stby_s; (reference_power_on && !bias_power_on) [*2]; endsequence
    a_pd_hiz: assert property (down_s |-> !lvds_out.data_oe && !lvds_out.dco_oe)
        else $error("drivers on in power-down");
    a_stby_hiz: assert property (stby_s |-> !lvds_out.dco_oe)
        else $error("drivers on in standby");
    a_pd_clk_stop: assert property (down_s ##1 !reference_power_on |-> $stable(internal_sample_clk))
        else $error("clock runs in power-down");
    a_dco_follows: assert property (rstn |-> lvds_out.data_capture_clock_out == internal_sample_clk)
        else $error("dco apart from sample clock");
    a_oe_pair: assert property (lvds_out.data_oe |-> lvds_out.dco_oe)
        else $error("data on without dco");
    a_bias_needs_ref: assert property (bias_power_on |-> reference_power_on)
        else $error("bias on with reference off");
    a_sdio_idle: assert property (spi_csb [*4] |-> !spi_sdio_oe)
        else $error("sdio driven outside frame");
    a_vref_hold: assert property (spi_csb [*8] |-> $stable(vref_trim))
        else $error("reference changed outside frame");
endmodule // adc_ctrl_monitor
bind adc_clock_power_output_ctrl adc_ctrl_monitor u_mon (.ref_clk, .rstn, .spi_csb,
    .spi_sdio_oe, .lvds_out, .internal_sample_clk, .reference_power_on, .bias_power_on,
    .vref_trim);

// ===== sim/capture_model.sv
`timescale 1ns/1ps
// far-side register taking words beside the data capture clock
module capture_model (
    // clock and lvds pins
    input wire logic                       ref_clk,
    input wire adc_ctrl_pkg::lvds_out_type lvds,
    // captured word
    output logic [10:0]                    word
);
    // take a word only while drivers are on and dco is high
    always @(posedge ref_clk) begin
        if (lvds.data_oe && lvds.data_capture_clock_out) begin
            word <= lvds.data;
        end
    end
endmodule // capture_model

// ===== sim/testbench.sv
`timescale 1ns/1ps
// serial port and sample driver, lvds judge
module testbench;
    logic                       ref_clk, rstn, sclk, csb, sdi;
    logic [10:0]                core_sample;
    logic [7:0]                 rd;
    logic [10:0]                fmt_exp [3] = '{11'h2aa, 11'h6aa, 11'h3ff};
    wire                        sdo, sdo_oe, int_clk, ref_on, bias_on, req_en;
    wire  [7:0]                 vref;
    wire  [10:0]                word;
    adc_ctrl_pkg::lvds_out_type lvds;
    int                         err_count, cmp_count, cyc;
    adc_clock_power_output_ctrl u_dut (.ref_clk, .rstn, .core_sample, .spi_sclk(sclk),
        .spi_csb(csb), .spi_sdio_in(sdo_oe ? sdo : sdi), .spi_sdio_out(sdo),
        .spi_sdio_oe(sdo_oe), .lvds_out(lvds), .internal_sample_clk(int_clk),
        .reference_power_on(ref_on), .bias_power_on(bias_on), .vref_trim(vref),
        .requantizer_enable(req_en));
    capture_model u_cap (.ref_clk, .lvds, .word);
    initial begin
        ref_clk = 0;
        forever #12.5 ref_clk = ~ref_clk;
    end
    // hang guard
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    task automatic check(input logic [10:0] got, input logic [10:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one frame: instruction then one byte, read byte left in rd
    task automatic spi(input logic [15:0] ins, input logic [7:0] wd);
        logic [23:0] sh;
        sh = {ins, wd};
        csb = 0;
        for (int i = 23; i >= 0; i--) begin
            sdi = sh[i];
            repeat (6) @(posedge ref_clk);
            rd = {rd[6:0], sdo};
            #1 sclk = 1;
            repeat (6) @(posedge ref_clk);
            #1 sclk = 0;
        end
        repeat (4) @(posedge ref_clk);
        #1 csb = 1;
        repeat (300) @(posedge ref_clk);
        #1;
    endtask
    task automatic t_latency(input int lat);
        core_sample = 11'h155;
        repeat (20) @(posedge ref_clk);
        #1 core_sample = 11'h2aa;
        repeat (lat) @(posedge ref_clk);
        #1 check(lvds.data, 11'h555);
        @(posedge ref_clk);
        #1 check(lvds.data, 11'h6aa);
    endtask
    task automatic complete_run();
        $display("mismatches %0d comparisons %0d", err_count, cmp_count);
        if (err_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        {rstn, sclk, sdi, core_sample} = '0;
        csb = 1;
        repeat (5) @(posedge ref_clk);
        #1 rstn = 1;
        spi(16'h8014, 8'h00);
        check(11'(rd), 11'h001);
        spi(16'h8008, 8'h00);
        check(11'({rd, bias_on, lvds.data_oe}), 11'h003);
        spi(16'h0009, 8'h01);
        t_latency(adc_ctrl_pkg::LATENCY_PLAIN);
        spi(16'h003c, 8'h01);
        check(11'({req_en, int_clk}), 11'h003);
        t_latency(adc_ctrl_pkg::LATENCY_REQUANT);
        spi(16'h003c, 8'h00);
        for (int f = 0; f < 3; f++) begin
            spi(16'h0014, 8'(f));
            check(word, fmt_exp[f]);
        end
        spi(16'h0014, 8'h51);
        check(11'({lvds.data_oe, lvds.dco_oe, lvds.reduced_swing}), 11'h003);
        spi(16'h0008, 8'h01);
        check(11'({ref_on, bias_on, lvds.data_oe, lvds.dco_oe}), 11'h000);
        spi(16'h0008, 8'h02);
        check(11'({ref_on, bias_on, lvds.dco_oe}), 11'h004);
        spi(16'h0018, 8'h5a);
        spi(16'h0008, 8'h00);
        check(11'({vref, bias_on, lvds.dco_oe}), 11'h16b);
        spi(16'h000b, 8'h01);
        rd[0] = int_clk;
        @(posedge ref_clk);
        #1 check(11'(int_clk ^ rd[0]), 11'h001);
        complete_run();
    end
endmodule // testbench
